/* File: core/jbst_cell_chain.v */
// jbst_cell_chain: capture, shift and update stages of all pad cells
module jbst_cell_chain #(
    parameter CELLS = 24
) (
    input wire clk,
    input wire rst,
    input wire capture_en,
    input wire shift_en,
    input wire update_en,
    input wire serial_in,
    input wire [CELLS-1:0] par_in,
    output wire serial_out,
    output reg [CELLS-1:0] par_out
);
    reg [CELLS-1:0] shift_stage;

    // cell 0 is nearest tdo, the top cell is fed from tdi
    assign serial_out = shift_stage[0];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_stage <= {CELLS{1'b0}};
            par_out <= {CELLS{1'b0}};
        end else begin
            if (capture_en) begin
                shift_stage <= par_in;
            end else if (shift_en) begin
                shift_stage <= {serial_in, shift_stage[CELLS-1:1]};
            end
            if (update_en) begin
                par_out <= shift_stage;
            end
        end
    end
endmodule // jbst_cell_chain

/* File: core/jbst_consts.vh */
// constants of the boundary scan test access port
`ifndef JBST_CONSTS_VH
`define JBST_CONSTS_VH

// instruction register
`define JBST_IR_W 8
`define JBST_IR_CAPTURE 8'h01
`define JBST_OP_EXTEST 8'h00
`define JBST_OP_SAMPLE 8'h01
`define JBST_OP_CLAMP 8'h05
`define JBST_OP_HIGHZ 8'h07
`define JBST_OP_USERCODE 8'h0E
`define JBST_OP_IDCODE 8'h0F
`define JBST_OP_BYPASS 8'hFF

// identification register layout
`define JBST_ID_W 32
`define JBST_ID_MARK_POS 0
`define JBST_ID_MFR_LSB 1
`define JBST_ID_MFR_W 11
`define JBST_ID_PART_LSB 12
`define JBST_ID_PART_W 16
`define JBST_ID_VER_LSB 28
`define JBST_ID_VER_W 4

// boundary cells per pad and their positions inside a pad group
`define JBST_CELLS_PER_PAD 3
`define JBST_CELL_IN 0
`define JBST_CELL_OUT 1
`define JBST_CELL_OE 2

// data register selector codes
`define JBST_SEL_BYPASS 2'h0
`define JBST_SEL_ID 2'h1
`define JBST_SEL_USER 2'h2
`define JBST_SEL_CHAIN 2'h3

// tdo buffer
`define JBST_TDO_FIFO_DEPTH 8

`endif

/* File: core/jbst_fifo.v */
// synchronous fifo with valid/ready on both sides
module jbst_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // jbst_fifo

/* File: core/jbst_tap.v */
// test access port controller, instruction decode and data registers
`include "jbst_consts.vh"

////////////////////////////////////////////////////////////////////////////
module jbst_tap #(
    parameter NUM_PADS = 8,
    parameter [10:0] MFR_CODE = 11'h155,
    parameter [15:0] PART_CODE = 16'h1234,
    parameter [3:0] VERSION_CODE = 4'h1,
    parameter [31:0] USER_CODE = 32'h0000_0000
) (
    input wire clk,
    input wire rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trst_n,
    input wire device_programmed,
    input wire [NUM_PADS-1:0] core_out,
    input wire [NUM_PADS-1:0] core_oe,
    input wire [NUM_PADS-1:0] pad_in,
    output reg tdo,
    output reg tdo_oe,
    output reg io_en,
    output reg [NUM_PADS-1:0] pad_out,
    output reg [NUM_PADS-1:0] pad_oe,
    output reg [NUM_PADS-1:0] core_in
);
    localparam CELLS = NUM_PADS * `JBST_CELLS_PER_PAD;

    // controller states, standard four bit codes
    localparam [3:0] ST_EX2_DR = 4'h0;
    localparam [3:0] ST_EX1_DR = 4'h1;
    localparam [3:0] ST_SHIFT_DR = 4'h2;
    localparam [3:0] ST_PAUSE_DR = 4'h3;
    localparam [3:0] ST_SEL_IR = 4'h4;
    localparam [3:0] ST_UPD_DR = 4'h5;
    localparam [3:0] ST_CAP_DR = 4'h6;
    localparam [3:0] ST_SEL_DR = 4'h7;
    localparam [3:0] ST_EX2_IR = 4'h8;
    localparam [3:0] ST_EX1_IR = 4'h9;
    localparam [3:0] ST_SHIFT_IR = 4'hA;
    localparam [3:0] ST_PAUSE_IR = 4'hB;
    localparam [3:0] ST_IDLE = 4'hC;
    localparam [3:0] ST_UPD_IR = 4'hD;
    localparam [3:0] ST_CAP_IR = 4'hE;
    localparam [3:0] ST_RESET = 4'hF;

    localparam [31:0] ID_VALUE = {VERSION_CODE, PART_CODE, MFR_CODE, 1'b1};

    function [3:0] tap_next;
        input [3:0] st;
        input m;
        begin
            case (st)
                ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
                ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: tap_next = m ? ST_EX1_DR : ST_SHIFT_DR;
                ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: tap_next = m ? ST_EX2_DR : ST_PAUSE_DR;
                ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: tap_next = m ? ST_EX1_IR : ST_SHIFT_IR;
                ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: tap_next = m ? ST_EX2_IR : ST_PAUSE_IR;
                ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
                default: tap_next = ST_RESET;
            endcase
        end
    endfunction

    // data register selected by an opcode
    function [1:0] dr_select;
        input [7:0] op;
        begin
            if (op == `JBST_OP_EXTEST || op == `JBST_OP_SAMPLE) begin
                dr_select = `JBST_SEL_CHAIN;
            end else if (op == `JBST_OP_IDCODE) begin
                dr_select = `JBST_SEL_ID;
            end else if (op == `JBST_OP_USERCODE) begin
                dr_select = `JBST_SEL_USER;
            end else begin
                dr_select = `JBST_SEL_BYPASS;
            end
        end
    endfunction

    // chain position of one cell of a pad
    function integer cell_at;
        input integer pad;
        input integer pos;
        begin
            cell_at = pad * `JBST_CELLS_PER_PAD + pos;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    reg [2:0] tck_sync;
    reg [1:0] tms_sync;
    reg [1:0] tdi_sync;
    reg [1:0] trst_sync;
    reg [NUM_PADS-1:0] pad_s1;
    reg [NUM_PADS-1:0] pad_s2;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tck_sync <= 3'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h3;
            trst_sync <= 2'h0;
            pad_s1 <= {NUM_PADS{1'b0}};
            pad_s2 <= {NUM_PADS{1'b0}};
        end else begin
            tck_sync <= {tck_sync[1:0], tck};
            tms_sync <= {tms_sync[0], tms};
            tdi_sync <= {tdi_sync[0], tdi};
            trst_sync <= {trst_sync[0], trst_n};
            pad_s1 <= pad_in;
            pad_s2 <= pad_s1;
        end
    end

    wire tck_rise = tck_sync[1] & ~tck_sync[2];
    wire tck_fall = ~tck_sync[1] & tck_sync[2];
    wire tms_now = tms_sync[1];
    wire tdi_now = tdi_sync[1];
    wire trst_active = ~trst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // controller and instruction register

    reg [3:0] state;
    reg [7:0] ir;
    reg [7:0] ir_shift;
    reg bypass_bit;
    reg [31:0] word_shift;

    wire [1:0] dr_sel = dr_select(ir);
    wire in_dr_cap = tck_rise & (state == ST_CAP_DR);
    wire in_dr_shift = tck_rise & (state == ST_SHIFT_DR);
    wire in_dr_upd = tck_rise & (state == ST_UPD_DR);
    wire chain_sel = (dr_sel == `JBST_SEL_CHAIN);
    wire chain_so;
    wire [CELLS-1:0] chain_upd;
    reg [CELLS-1:0] chain_par_in;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_RESET;
            ir <= `JBST_OP_IDCODE;
            ir_shift <= {`JBST_IR_W{1'b0}};
            bypass_bit <= 1'b0;
            word_shift <= {`JBST_ID_W{1'b0}};
        end else if (trst_active) begin
            state <= ST_RESET;
            ir <= `JBST_OP_IDCODE;
        end else if (tck_rise) begin
            state <= tap_next(state, tms_now);
            case (state)
                ST_RESET: begin
                    ir <= `JBST_OP_IDCODE;
                end
                ST_CAP_IR: begin
                    ir_shift <= `JBST_IR_CAPTURE;
                end
                ST_SHIFT_IR: begin
                    ir_shift <= {tdi_now, ir_shift[7:1]};
                end
                ST_UPD_IR: begin
                    ir <= ir_shift;
                end
                ST_CAP_DR: begin
                    bypass_bit <= 1'b0;
                    if (dr_sel == `JBST_SEL_USER) begin
                        word_shift <= USER_CODE;
                    end else begin
                        word_shift <= ID_VALUE;
                    end
                end
                ST_SHIFT_DR: begin
                    bypass_bit <= tdi_now;
                    word_shift <= {tdi_now, word_shift[31:1]};
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // boundary cells

    integer i;
    integer j;

    always @* begin
        chain_par_in = {CELLS{1'b0}};
        for (i = 0; i < NUM_PADS; i = i + 1) begin
            chain_par_in[cell_at(i, `JBST_CELL_IN)] = pad_s2[i];
            chain_par_in[cell_at(i, `JBST_CELL_OUT)] = core_out[i];
            chain_par_in[cell_at(i, `JBST_CELL_OE)] = core_oe[i];
        end
    end

    // an unprogrammed device skips the capture so old contents remain
    jbst_cell_chain #(
        .CELLS(CELLS)
    ) u_chain (
        .clk(clk),
        .rst(rst),
        .capture_en(in_dr_cap & chain_sel & device_programmed),
        .shift_en(in_dr_shift & chain_sel & ~trst_active),
        .update_en(in_dr_upd & chain_sel & ~trst_active),
        .serial_in(tdi_now),
        .par_in(chain_par_in),
        .serial_out(chain_so),
        .par_out(chain_upd)
    );

    ////////////////////////////////////////////////////////////////////////
    // pad control

    wire force_mode = (ir == `JBST_OP_EXTEST) || (ir == `JBST_OP_CLAMP);
    wire float_mode = (ir == `JBST_OP_HIGHZ);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            io_en <= 1'b0;
            pad_out <= {NUM_PADS{1'b0}};
            pad_oe <= {NUM_PADS{1'b0}};
            core_in <= {NUM_PADS{1'b0}};
        end else begin
            io_en <= device_programmed;
            for (j = 0; j < NUM_PADS; j = j + 1) begin
                if (!device_programmed) begin
                    pad_out[j] <= 1'b0;
                    pad_oe[j] <= 1'b0;
                    core_in[j] <= 1'b0;
                end else if (force_mode) begin
                    pad_out[j] <= chain_upd[cell_at(j, `JBST_CELL_OUT)];
                    pad_oe[j] <= chain_upd[cell_at(j, `JBST_CELL_OE)];
                    core_in[j] <= chain_upd[cell_at(j, `JBST_CELL_IN)];
                end else if (float_mode) begin
                    pad_out[j] <= core_out[j];
                    pad_oe[j] <= 1'b0;
                    core_in[j] <= pad_s2[j];
                end else begin
                    pad_out[j] <= core_out[j];
                    pad_oe[j] <= core_oe[j];
                    core_in[j] <= pad_s2[j];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // test data output through the buffer

    reg dr_bit;
    reg fall_pend;
    reg fall_bit;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_data;
    wire in_shift = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);

    always @* begin
        if (dr_sel == `JBST_SEL_CHAIN) begin
            dr_bit = chain_so;
        end else if (dr_sel == `JBST_SEL_BYPASS) begin
            dr_bit = bypass_bit;
        end else begin
            dr_bit = word_shift[0];
        end
    end

    // one bit per falling edge in shift-dr or shift-ir; held until the buffer accepts it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fall_pend <= 1'b0;
            fall_bit <= 1'b0;
        end else if (tck_fall && in_shift) begin
            fall_pend <= 1'b1;
            fall_bit <= (state == ST_SHIFT_IR) ? ir_shift[0] : dr_bit;
        end else if (fifo_in_ready) begin
            fall_pend <= 1'b0;
        end
    end

    jbst_fifo #(
        .WIDTH(1),
        .DEPTH(`JBST_TDO_FIFO_DEPTH),
        .AW(3)
    ) u_tdo_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fall_pend),
        .in_ready(fifo_in_ready),
        .in_data(fall_bit),
        .out_valid(fifo_out_valid),
        .out_ready(~tck_sync[1]),
        .out_data(fifo_out_data)
    );

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (trst_active) begin
            // bits leaving the buffer while tck is low during a test reset are dropped undriven
            tdo_oe <= 1'b0;
        end else if (fifo_out_valid && !tck_sync[1]) begin
            tdo <= fifo_out_data;
            tdo_oe <= 1'b1;
        end else if (tck_fall && !in_shift) begin
            tdo_oe <= 1'b0;
        end
    end
endmodule // jbst_tap

/* File: dv/jbst_tap_chk.sv */
// assertions on the pins of the boundary scan access port
module jbst_tap_chk #(
    parameter NUM_PADS = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic trst_n,
    input wire logic device_programmed,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic io_en,
    input wire logic [NUM_PADS-1:0] pad_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tck_q;
    logic [2:0] ones;

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // counts consecutive test clock rises seen with tms high, cleared by a rise with tms low, saturating at seven
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tck_q <= 1'h0;
            ones <= 3'h0;
        end else begin
            tck_q <= tck;
            if (tck && !tck_q) begin
                ones <= !tms ? 3'h0 : (ones == 3'h7 ? 3'h7 : ones + 3'h1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    rst_vals_a: assert property ($fell(rst) |-> !tdo && !tdo_oe && !io_en)
        else $error("outputs not idle after reset");
    io_follow_a: assert property (!$past(rst) |->
        io_en == $past(device_programmed))
        else $error("pad enable does not follow programmed state");
    pads_off_a: assert property (!io_en && !$past(io_en) |-> pad_oe == '0)
        else $error("pad driven while device unprogrammed");
    trst_oe_a: assert property ($fell(trst_n) ##1 !trst_n [*2] |->
        ##[0:4] !tdo_oe)
        else $error("test reset did not stop tdo drive");
    trst_hold_a: assert property (!trst_n [*8] |-> !tdo_oe)
        else $error("tdo driven while test reset held");
    oe_tck_low_a: assert property ($changed(tdo_oe) && trst_n &&
        $past(trst_n, 6) |-> !tck)
        else $error("tdo enable moved while test clock high");
    tdo_tck_low_a: assert property ($changed(tdo) && trst_n &&
        $past(trst_n, 6) |-> !tck)
        else $error("tdo moved while test clock high");
    tms_reset_a: assert property (ones >= 3'h3 |-> !tdo_oe)
        else $error("tdo driven after tms held high");
endmodule // jbst_tap_chk

bind jbst_tap jbst_tap_chk #(.NUM_PADS(NUM_PADS)) u_chk (
    .clk(clk),
    .rst(rst),
    .tck(tck),
    .tms(tms),
    .trst_n(trst_n),
    .device_programmed(device_programmed),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .io_en(io_en),
    .pad_oe(pad_oe)
);

/* File: dv/jbst_tester.sv */
// tester model driving the test access pins
module jbst_tester (
    input wire logic clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    output logic got_v,
    output logic [31:0] got_d
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
        trst_n = 1'h1;
        got_v = 1'h0;
        got_d = '0;
    end

    // levels change at the fall and tdo is read just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tck <= 1'h0;
        tms <= m;
        tdi <= d;
        repeat (6) @(posedge clk);
        // an undriven tdo reads as the inverse of its last level
        q = tdo_oe ? tdo : ~tdo;
        tck <= 1'h1;
        repeat (4) @(posedge clk);
    endtask

    // tms pattern sent lsb first; tdi rests high like its pull-up
    task automatic walk(input logic [7:0] pat, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            step(pat[i], 1'h1, q);
        end
    endtask

    // shift from capture, leave via exit1 and update to idle, report word
    task automatic shift(input logic [31:0] din, input int n);
        logic q;
        logic [31:0] acc;
        acc = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            acc[i] = q;
        end
        walk(8'h01, 2);
        got_d <= acc;
        got_v <= 1'h1;
        @(posedge clk);
        got_v <= 1'h0;
    endtask

    task automatic pulse_trst();
        trst_n <= 1'h0;
        repeat (10) @(posedge clk);
        trst_n <= 1'h1;
        repeat (4) @(posedge clk);
    endtask
endmodule // jbst_tester

/* File: dv/testbench.sv */
// self-checking bench for the boundary scan access port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 8;
    localparam logic [10:0] MFR = 11'h2A5; // arbitrary
    localparam logic [15:0] PART = 16'hC3B1; // arbitrary
    localparam logic [3:0] VER = 4'h6; // arbitrary
    localparam logic [31:0] UCODE = 32'h5EED_0042; // arbitrary
    localparam logic [31:0] IDW = {VER, PART, MFR, 1'h1};
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic prog = 1'h1;
    logic pad_v = 1'h0;
    logic [NP-1:0] core_out = '0;
    logic [NP-1:0] core_oe = '0;
    logic [NP-1:0] pad_in = '0;
    logic [NP-1:0] pad_out, pad_oe, core_in;
    logic tdo, tdo_oe, io_en, tck, tms, tdi, trst_n, got_v;
    logic [31:0] got_d, g, r, e, m;
    logic [63:0] ent;
    logic [63:0] expq[$];
    logic [23:0] held;
    logic [7:0] ops[8] = '{8'h01, 8'h00, 8'h05, 8'h07, 8'h0E, 8'h0F, 8'hFF,
        8'h3C};
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    jbst_tap #(.NUM_PADS(NP), .MFR_CODE(MFR), .PART_CODE(PART),
        .VERSION_CODE(VER), .USER_CODE(UCODE)) dut (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .device_programmed(prog), .core_out(core_out),
        .core_oe(core_oe), .pad_in(pad_in), .tdo(tdo), .tdo_oe(tdo_oe),
        .io_en(io_en), .pad_out(pad_out), .pad_oe(pad_oe),
        .core_in(core_in));
    jbst_tester u_tst (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .got_v(got_v),
        .got_d(got_d));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] cells(input logic [7:0] i, o, x);
        logic [23:0] c;
        for (int p = 0; p < NP; p++) begin
            c[3 * p] = i[p];
            c[3 * p + 1] = o[p];
            c[3 * p + 2] = x[p];
        end
        return c;
    endfunction

    // chain contents seen as {core_in, pad_oe, pad_out}
    function automatic logic [23:0] split(input logic [23:0] c);
        logic [23:0] s;
        for (int p = 0; p < NP; p++) begin
            s[16 + p] = c[3 * p];
            s[8 + p] = c[3 * p + 2];
            s[p] = c[3 * p + 1];
        end
        return s;
    endfunction

    task automatic load_ir(input logic [7:0] op);
        u_tst.walk(8'h03, 4);
        expq.push_back({32'h0000_00FF, 32'h0000_0001});
        u_tst.shift({24'h0, op}, 8);
    endtask

    task automatic read_dr(input logic [31:0] din, x, k);
        u_tst.walk(8'h01, 3);
        expq.push_back({k, x});
        u_tst.shift(din, 32);
    endtask

    task automatic look(input logic [31:0] x, k);
        expq.push_back({k, x});
        pad_v <= 1'h1;
        @(posedge clk);
        pad_v <= 1'h0;
        @(posedge clk);
    endtask

    task automatic wrap_up();
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (got_v === 1'h1 || pad_v === 1'h1) begin
            g = got_v ? got_d : {7'h0, io_en, core_in, pad_oe, pad_out};
            ent = expq.size() ? expq.pop_front() : {32'hFFFF_FFFF, ~g};
            total_checks++;
            if ((g & ent[63:32]) !== (ent[31:0] & ent[63:32])) begin
                err_total++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, g, ent[31:0]);
            end
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
            wrap_up();
        end
    end

    initial begin
        r = $urandom(32'h5C19);
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        repeat (6) @(posedge clk);
        u_tst.walk(8'h00, 1);
        read_dr($urandom, IDW, '1);
        foreach (ops[k]) begin
            core_out <= $urandom;
            core_oe <= $urandom;
            pad_in <= $urandom;
            r = $urandom;
            load_ir(ops[k]);
            m = (ops[k] == 8'h00) ? 32'hFF00_0000 : '1;
            case (ops[k])
                8'h00, 8'h01: e = {r[7:0], cells(pad_in, core_out, core_oe)};
                8'h0E: e = UCODE;
                8'h0F: e = IDW;
                default: e = {r[30:0], 1'h0};
            endcase
            read_dr(r, e, m);
            if (ops[k] == 8'h00) begin
                held = r[31:8];
            end
            case (ops[k])
                8'h00, 8'h05: look({8'h01, split(held)}, 32'h01FF_FFFF);
                8'h07: look(32'h0100_0000, 32'h0100_FF00);
                8'h0F: look({8'h01, pad_in, core_oe, core_out}, '1);
                default: ;
            endcase
        end
        load_ir(8'hFF);
        u_tst.walk(8'h01, 3);
        u_tst.walk(8'h00, 4);
        u_tst.walk(8'h1F, 5);
        u_tst.walk(8'h00, 1);
        read_dr($urandom, IDW, '1);
        load_ir(8'hFF);
        u_tst.walk(8'h01, 4);
        u_tst.pulse_trst();
        u_tst.walk(8'h00, 1);
        read_dr($urandom, IDW, '1);
        prog <= 1'h0;
        r = $urandom;
        load_ir(8'h01);
        read_dr(r, {r[7:0], 24'h0}, 32'hFF00_0000);
        look(32'h0, 32'h0100_FF00);
        repeat (4) @(posedge clk);
        if (expq.size() != 0) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, expq.size(), 0);
        end
        wrap_up();
    end
endmodule // testbench
